/* File: core/osc_select_pkg.sv */
// Package for the reset clock source selection block.
// Assumes one 200 MHz core clock and a synchronous active-high reset.
package osc_select_pkg;

   // ----------------------------------------------------------------
   // Source codes of the reset oscillator field
   // ----------------------------------------------------------------
   localparam logic [1:0] SRC_EXTERNAL  = 2'h3;   // External logic-level clock
   localparam logic [1:0] SRC_HF_1MHZ   = 2'h2;   // High-freq internal, 1 MHz
   localparam logic [1:0] SRC_LF_INT    = 2'h1;   // Low-freq internal, 31 kHz
   localparam logic [1:0] SRC_HF_32MHZ  = 2'h0;   // High-freq internal, 32 MHz

   // ----------------------------------------------------------------
   // Frequency selection codes
   // ----------------------------------------------------------------
   localparam logic [2:0] FRQ_RESET_EXT = 3'h4;   // Reset value for external choice
   localparam logic [2:0] FRQ_1MHZ      = 3'h0;   // Code for 1 MHz
   localparam logic [2:0] FRQ_32MHZ     = 3'h6;   // Code for 32 MHz

   // ----------------------------------------------------------------
   // Trim field layout
   // ----------------------------------------------------------------
   localparam int         TRIM_W        = 6;      // Trim width
   localparam logic [5:0] TRIM_DEFAULT  = 6'h00;  // Nominal frequency
   localparam logic [5:0] TRIM_UP_MAX   = 6'h1F;  // Highest raising value
   localparam logic [5:0] TRIM_DN_MIN   = 6'h20;  // Lowest lowering value

   // ----------------------------------------------------------------
   // Instruction clock divider
   // ----------------------------------------------------------------
   localparam int         DIV_W         = 2;      // Divide by four counter
   localparam logic [1:0] DIV_HALF      = 2'h1;   // Toggle point of the output

   // Source kind decoded from the code
   typedef enum logic [1:0] {KIND_EXT, KIND_HF, KIND_LF} src_kind_e;

endpackage : osc_select_pkg

/* File: core/instr_clock_div.sv */
// Divide-by-four instruction clock generator with a pin driver.
// Assumes the system clock tick arrives as a same-domain strobe.
module instr_clock_div
(
   input  wire logic mclk,           // Core clock
   input  wire logic reset,          // Synchronous, active high
   input  wire logic sysTick,        // One pulse per system clock cycle
   input  wire logic outDisableN,    // Clock out disable, low drives pin
   output logic      pinOut,         // Clock pin output value
   output logic      pinOeN,         // Low while the pin is driven
   output logic      instrClock      // Instruction clock level
);

   // ----------------------------------------------------------------
   // Divider
   // ----------------------------------------------------------------
   logic [osc_select_pkg::DIV_W-1:0] divCnt_ff;     // Phase counter
   logic [osc_select_pkg::DIV_W-1:0] nxt_divCnt;    // Next phase
   logic                             clk4_ff;       // Registered quarter clock
   logic                             nxt_clk4;      // Next quarter clock

   // Wraps from three to zero; the cast drops the carry out on purpose
   assign nxt_divCnt = sysTick ? osc_select_pkg::DIV_W'(divCnt_ff + 2'h1) : divCnt_ff;
   // High for two ticks, low for two: a clean 50 percent duty output
   assign nxt_clk4   = (nxt_divCnt > osc_select_pkg::DIV_HALF);

   // Counter and output flop
   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         divCnt_ff <= '0;
         clk4_ff   <= 1'b0;
      end
      else
      begin
         divCnt_ff <= nxt_divCnt;
         clk4_ff   <= nxt_clk4;
      end
   end

   assign instrClock = clk4_ff;
   // Pin released to general I/O when the disable bit is high
   assign pinOut = outDisableN ? 1'b0 : clk4_ff;
   assign pinOeN = outDisableN;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   chk_pin_released: assert property (@(posedge mclk) disable iff (reset)
      outDisableN |-> (pinOeN && !pinOut))
      else $error("clock pin driven while disabled");
   chk_pin_follows: assert property (@(posedge mclk) disable iff (reset)
      !outDisableN |-> (!pinOeN && pinOut == clk4_ff))
      else $error("clock pin not carrying instruction clock");
   cov_pin_toggle: cover property (@(posedge mclk) disable iff (reset)
      !outDisableN && $rose(pinOut));

endmodule : instr_clock_div

/* File: core/reset_clock_source_select.sv */
// Reset clock source selection: latches the reset oscillator code,
// picks the system clock, reports the current source and drives the
// instruction clock pin.
// Assumes oscillator ticks are asynchronous pins, already square waves,
// and configuration fields are static nonvolatile values.
//
// Overview of operation
// - Reset code picks source, copied to current
// - Selection at power-up too; sets start frequency
// - Low-freq oscillator fixed 31 kHz, untouched
// - High-freq frequency follows frequency select
// - Separate converter RC clock provided
// - Disable bit low drives instruction clock out
// - Disable bit high leaves pin as I/O
// - Current source readable as two bits
// - Trim two's complement, up or down
module reset_clock_source_select
(
   input  wire logic       mclk,               // Core clock, 200 MHz
   input  wire logic       reset,              // Synchronous, active high
   input  wire logic [1:0] resetOscSelect,     // Reset oscillator configuration code
   input  wire logic       extClockModeSelect, // 1 high power, 0 low power
   input  wire logic       clockOutDisableN,   // Clock out configuration bit
   input  wire logic       externalOsc,        // External clock pin
   input  wire logic       highFreqInternalOsc,// High-freq internal osc raw
   input  wire logic       lowFreqInternalOsc, // Low-freq internal osc raw
   input  wire logic       converterRcOsc,     // Converter RC osc raw
   input  wire logic       hfFreqWrite,        // Strobe: load new frequency select
   input  wire logic [2:0] hfFreqWriteData,    // New frequency select value
   input  wire logic       trimWrite,          // Strobe: load new trim
   input  wire logic [5:0] trimWriteData,      // New trim value
   output logic [1:0]      currentOscSource,   // Read-only current source
   output logic [2:0]      hfFreqSelect,       // Frequency select to the oscillator
   output logic [5:0]      freqTrim,           // Trim to the oscillator
   output logic            trimRaise,          // Trim pushes frequency up
   output logic            trimLower,          // Trim pushes frequency down
   output logic            extHighPower,       // External high-power mode active
   output logic            extLowPower,        // External low-power mode active
   output logic            sysClockTick,       // Pulse per system clock edge
   output logic            converterClockTick, // Pulse per converter RC edge
   output logic            instrClock,         // Instruction clock level
   output logic            instrClockOutPin,   // Clock out pin value
   output logic            instrClockOutOeN    // Pin enable, low drives
);

   // ----------------------------------------------------------------
   // Functions
   // ----------------------------------------------------------------
   // Decode a code to its kind; both high-freq codes share one kind
   function automatic osc_select_pkg::src_kind_e kind_of(input logic [1:0] code);
      osc_select_pkg::src_kind_e k;
      k = osc_select_pkg::KIND_HF;
      if (code == osc_select_pkg::SRC_EXTERNAL)
         k = osc_select_pkg::KIND_EXT;
      else if (code == osc_select_pkg::SRC_LF_INT)
         k = osc_select_pkg::KIND_LF;
      return k;
   endfunction : kind_of

   // Reset frequency select for a given source code
   function automatic logic [2:0] reset_freq(input logic [1:0] code);
      logic [2:0] f;
      f = osc_select_pkg::FRQ_RESET_EXT;
      if (code == osc_select_pkg::SRC_HF_1MHZ)
         f = osc_select_pkg::FRQ_1MHZ;
      else if (code == osc_select_pkg::SRC_HF_32MHZ)
         f = osc_select_pkg::FRQ_32MHZ;
      return f;
   endfunction : reset_freq

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic [3:0] syncA_ff;     // First stage, read only by second stage
   logic [3:0] syncB_ff;     // Second stage
   logic [3:0] syncC_ff;     // Edge history
   logic [3:0] rawPins;      // Bundled oscillator pins
   logic [3:0] risePulse;    // Rising edges, one cycle

   // Order: 0 external, 1 high-freq, 2 low-freq, 3 converter RC
   assign rawPins = {converterRcOsc, lowFreqInternalOsc, highFreqInternalOsc, externalOsc};

   // Two-flop crossing plus edge history
   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         syncA_ff <= 4'h0;
         syncB_ff <= 4'h0;
         syncC_ff <= 4'h0;
      end
      else
      begin
         syncA_ff <= rawPins;
         syncB_ff <= syncA_ff;
         syncC_ff <= syncB_ff;
      end
   end

   assign risePulse = syncB_ff & ~syncC_ff;

   // ----------------------------------------------------------------
   // Source latch
   // ----------------------------------------------------------------
   logic [1:0] srcCode_ff;    // Latched source code
   logic [1:0] nxt_srcCode;   // Next code
   logic       extMode_ff;    // Latched external power mode
   logic       nxt_extMode;   // Next external mode

   // Only sampled while reset is high, so a live change is ignored
   assign nxt_srcCode = reset ? resetOscSelect : srcCode_ff;
   assign nxt_extMode = reset ? extClockModeSelect : extMode_ff;

   // Capture straps during reset, a clocked sample rather than async load
   always_ff @(posedge mclk)
   begin
      srcCode_ff <= nxt_srcCode;
      extMode_ff <= nxt_extMode;
   end

   osc_select_pkg::src_kind_e srcKind;   // Decoded kind
   assign srcKind          = kind_of(srcCode_ff);
   assign currentOscSource = srcCode_ff;
   // Mode outputs only meaningful for the external choice
   assign extHighPower = (srcKind == osc_select_pkg::KIND_EXT) && extMode_ff;
   assign extLowPower  = (srcKind == osc_select_pkg::KIND_EXT) && !extMode_ff;

   // ----------------------------------------------------------------
   // Frequency select and trim
   // ----------------------------------------------------------------
   logic [2:0] freq_ff;      // Frequency select register
   logic [2:0] nxt_freq;     // Next value
   logic [5:0] trim_ff;      // Trim register
   logic [5:0] nxt_trim;     // Next value

   assign nxt_freq = hfFreqWrite ? hfFreqWriteData : freq_ff;
   assign nxt_trim = trimWrite ? trimWriteData : trim_ff;

   // Reset loads per-source start frequency and nominal trim
   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         freq_ff <= reset_freq(resetOscSelect);
         trim_ff <= osc_select_pkg::TRIM_DEFAULT;
      end
      else
      begin
         freq_ff <= nxt_freq;
         trim_ff <= nxt_trim;
      end
   end

   assign hfFreqSelect = freq_ff;
   assign freqTrim     = trim_ff;
   // Sign bit picks direction; zero leaves the nominal frequency
   assign trimRaise = (trim_ff != osc_select_pkg::TRIM_DEFAULT) &&
                      (trim_ff <= osc_select_pkg::TRIM_UP_MAX);
   assign trimLower = (trim_ff >= osc_select_pkg::TRIM_DN_MIN);

   // ----------------------------------------------------------------
   // System clock selection
   // ----------------------------------------------------------------
   logic selTick;    // Tick of the chosen source
   // Low-freq tick is never steered by frequency select or trim
   assign selTick = (srcKind == osc_select_pkg::KIND_EXT) ? risePulse[0] :
                    (srcKind == osc_select_pkg::KIND_LF)  ? risePulse[2] :
                    risePulse[1];
   assign sysClockTick       = selTick;
   // Converter clock kept apart from the system clock mux
   assign converterClockTick = risePulse[3];

   // ----------------------------------------------------------------
   // Instruction clock out
   // ----------------------------------------------------------------
   instr_clock_div u_div
   (
      .mclk        (mclk),
      .reset       (reset),
      .sysTick     (selTick),
      .outDisableN (clockOutDisableN),
      .pinOut      (instrClockOutPin),
      .pinOeN      (instrClockOutOeN),
      .instrClock  (instrClock)
   );

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   chk_code_latched: assert property (@(posedge mclk)
      reset |=> (currentOscSource == $past(resetOscSelect)))
      else $error("current source not loaded from reset code");
   chk_code_held: assert property (@(posedge mclk)
      (!reset && !$past(reset)) |-> $stable(currentOscSource))
      else $error("current source changed outside reset");
   chk_freq_start: assert property (@(posedge mclk)
      (reset && resetOscSelect == osc_select_pkg::SRC_HF_32MHZ) |=>
         (hfFreqSelect == osc_select_pkg::FRQ_32MHZ))
      else $error("wrong start frequency");
   chk_freq_write: assert property (@(posedge mclk) disable iff (reset)
      hfFreqWrite |=> (hfFreqSelect == $past(hfFreqWriteData)))
      else $error("frequency select not updated");
   chk_trim_dir: assert property (@(posedge mclk) disable iff (reset)
      !(trimRaise && trimLower) && ((freqTrim[5]) == trimLower))
      else $error("trim direction wrong");
   chk_lf_source: assert property (@(posedge mclk) disable iff (reset)
      (srcKind == osc_select_pkg::KIND_LF) |-> (sysClockTick == risePulse[2]))
      else $error("low-freq source not selected");
   chk_ext_source: assert property (@(posedge mclk) disable iff (reset)
      (currentOscSource == osc_select_pkg::SRC_EXTERNAL) |->
         (sysClockTick == risePulse[0]) && (extHighPower != extLowPower))
      else $error("external source not selected");
   chk_conv_clock: assert property (@(posedge mclk) disable iff (reset)
      converterClockTick == (syncB_ff[3] && !syncC_ff[3]))
      else $error("converter tick wrong");

   cov_ext_boot: cover property (@(posedge mclk)
      reset ##1 !reset && currentOscSource == osc_select_pkg::SRC_EXTERNAL);
   cov_lf_boot: cover property (@(posedge mclk)
      reset ##1 !reset && currentOscSource == osc_select_pkg::SRC_LF_INT);
   cov_trim_down: cover property (@(posedge mclk) disable iff (reset) trimLower);

endmodule : reset_clock_source_select

/* File: tb/osc_source_model.sv */
// Far-side model: the oscillator pins seen by the clock select block.
// Assumes a 5 ns bench clock; periods are whole multiples of it.
module osc_source_model
(
   input  wire logic slowExt,             // 1 slows the external clock
   output logic      externalOsc,         // Logic-level external clock
   output logic      highFreqInternalOsc, // High-freq oscillator, scaled
   output logic      lowFreqInternalOsc,  // Low-freq oscillator, scaled
   output logic      converterRcOsc       // Converter RC oscillator
);
   timeunit 1ns;
   timeprecision 100ps;

   // ----------------------------------------------------------------
   // Free-running sources
   // ----------------------------------------------------------------
   // Edges land 1 ns after whole periods, well away from mclk edges,
   // so the sampled tick spacing is exact and never a race.
   // Rates are scaled far up; only the ratios matter to the block.
   initial
   begin
      externalOsc         = 1'b0;
      highFreqInternalOsc = 1'b0;
      lowFreqInternalOsc  = 1'b0;
      converterRcOsc      = 1'b0;
      #1;
      fork
         forever #(slowExt ? 45 : 20) externalOsc = ~externalOsc;
         forever #30 highFreqInternalOsc = ~highFreqInternalOsc;
         forever #50 lowFreqInternalOsc = ~lowFreqInternalOsc;
         forever #40 converterRcOsc = ~converterRcOsc;
      join
   end
endmodule : osc_source_model

/* File: tb/testbench.sv */
// Self-checking bench for the reset clock source select block.
// Assumes the design package is compiled first; drives at falling edges.
module testbench;
   timeunit 1ns;
   timeprecision 100ps;

   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   logic       mclk = 1'b0;            // Core clock, 5 ns
   logic       reset = 1'b1;           // Synchronous reset
   logic [1:0] resetOscSelect = 2'h0;  // Reset code
   logic       extClockModeSelect = 1'b1;
   logic       clockOutDisableN = 1'b1;
   logic       slowExt = 1'b0;         // Model rate choice
   logic       hfFreqWrite = 1'b0;
   logic [2:0] hfFreqWriteData = 3'h0;
   logic       trimWrite = 1'b0;
   logic [5:0] trimWriteData = 6'h00;
   logic       externalOsc, highFreqInternalOsc, lowFreqInternalOsc, converterRcOsc;
   logic [1:0] currentOscSource;
   logic [2:0] hfFreqSelect;
   logic [5:0] freqTrim;
   logic       trimRaise, trimLower, extHighPower, extLowPower;
   logic       sysClockTick, converterClockTick, instrClock;
   logic       instrClockOutPin, instrClockOutOeN;
   logic [2:0] watch;                  // Signals whose rise spacing is measured
   int         errors = 0;
   int         checks = 0;
   int         cycles = 0;
   int         n;
   logic [1:0] caseCode [5] = '{2'h3, 2'h3, 2'h2, 2'h1, 2'h0};
   logic       caseSlow [5] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
   logic [5:0] trimTab  [6] = '{6'h01, 6'h1F, 6'h20, 6'h3F, 6'h00, 6'h10};

   assign watch = {instrClock, converterClockTick, sysClockTick};

   always #2.5 mclk = ~mclk;

   // ----------------------------------------------------------------
   // Instances
   // ----------------------------------------------------------------
   osc_source_model model_u (.slowExt(slowExt), .externalOsc(externalOsc),
      .highFreqInternalOsc(highFreqInternalOsc), .lowFreqInternalOsc(lowFreqInternalOsc),
      .converterRcOsc(converterRcOsc));

   reset_clock_source_select dut_u (.mclk(mclk), .reset(reset),
      .resetOscSelect(resetOscSelect), .extClockModeSelect(extClockModeSelect),
      .clockOutDisableN(clockOutDisableN), .externalOsc(externalOsc),
      .highFreqInternalOsc(highFreqInternalOsc), .lowFreqInternalOsc(lowFreqInternalOsc),
      .converterRcOsc(converterRcOsc), .hfFreqWrite(hfFreqWrite),
      .hfFreqWriteData(hfFreqWriteData), .trimWrite(trimWrite),
      .trimWriteData(trimWriteData), .currentOscSource(currentOscSource),
      .hfFreqSelect(hfFreqSelect), .freqTrim(freqTrim), .trimRaise(trimRaise),
      .trimLower(trimLower), .extHighPower(extHighPower), .extLowPower(extLowPower),
      .sysClockTick(sysClockTick), .converterClockTick(converterClockTick),
      .instrClock(instrClock), .instrClockOutPin(instrClockOutPin),
      .instrClockOutOeN(instrClockOutOeN));

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
      end
   endtask : check

   task give_verdict;
      $display("Checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : give_verdict

   // Reset for 12 cycles with a code and external mode in place
   task automatic do_reset(input logic [1:0] code, input logic mode);
      @(negedge mclk);
      resetOscSelect     = code;
      extClockModeSelect = mode;
      reset              = 1'b1;
      repeat (12) @(negedge mclk);
      reset = 1'b0;
      @(negedge mclk);
   endtask : do_reset

   // One strobed write, then one idle cycle so strobes never abut
   task automatic wr(input logic isTrim, input logic [5:0] d);
      hfFreqWrite     = !isTrim;
      trimWrite       = isTrim;
      hfFreqWriteData = d[2:0];
      trimWriteData   = d;
      @(negedge mclk);
      hfFreqWrite = 1'b0;
      trimWrite   = 1'b0;
      @(negedge mclk);
   endtask : wr

   // Cycles from now to the next rise of a watched signal, bounded
   task automatic wait_rise(input int sel, output int k);
      logic prev;
      logic rose;
      prev = watch[sel];
      k    = 0;
      do
      begin
         @(negedge mclk);
         k++;
         rose = (prev === 1'b0) && (watch[sel] === 1'b1);
         prev = watch[sel];
      end while (!rose && k < 400);
   endtask : wait_rise

   task automatic rise_gap(input int sel, output int k);
      wait_rise(sel, k);
      wait_rise(sel, k);
   endtask : rise_gap

   // Expected tick spacing in cycles from the model's periods
   function automatic int exp_gap(input logic [1:0] code, input logic slow);
      if (code == osc_select_pkg::SRC_EXTERNAL)
         return slow ? 18 : 8;
      return (code == osc_select_pkg::SRC_LF_INT) ? 20 : 12;
   endfunction : exp_gap

   function automatic logic [2:0] exp_freq(input logic [1:0] code);
      if (code == osc_select_pkg::SRC_HF_1MHZ)
         return osc_select_pkg::FRQ_1MHZ;
      if (code == osc_select_pkg::SRC_HF_32MHZ)
         return osc_select_pkg::FRQ_32MHZ;
      return osc_select_pkg::FRQ_RESET_EXT;
   endfunction : exp_freq

   // ----------------------------------------------------------------
   // Hang guard
   // ----------------------------------------------------------------
   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 6000)
      begin
         errors++;
         give_verdict();
      end
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial
   begin
      // Every code; external case run fast in high power, slow in low
      for (int i = 0; i < 5; i++)
      begin
         slowExt = caseSlow[i];
         do_reset(caseCode[i], !caseSlow[i]);
         check("source", currentOscSource, caseCode[i]);
         check("freqsel", hfFreqSelect, exp_freq(caseCode[i]));
         check("trim", freqTrim, osc_select_pkg::TRIM_DEFAULT);
         check("highpwr", extHighPower, caseCode[i] == 2'h3 && !caseSlow[i]);
         check("lowpwr", extLowPower, caseCode[i] == 2'h3 && caseSlow[i]);
         resetOscSelect = ~caseCode[i];
         wr(1'b0, 6'h06);
         rise_gap(0, n);
         check("sysgap", 8'(n), 8'(exp_gap(caseCode[i], caseSlow[i])));
         rise_gap(1, n);
         check("rcgap", 8'(n), 8'h10);
         check("held", currentOscSource, caseCode[i]);
      end
      // Frequency select and trim writes
      for (int i = 0; i < 8; i++)
      begin
         wr(1'b0, 6'(i));
         check("freqwr", hfFreqSelect, 8'(i));
      end
      foreach (trimTab[i])
      begin
         wr(1'b1, trimTab[i]);
         check("trimwr", freqTrim, trimTab[i]);
         check("raise", trimRaise, !trimTab[i][5] && trimTab[i] != 6'h00);
         check("lower", trimLower, trimTab[i][5]);
      end
      // Instruction clock on the pin, system clock now 12 cycles
      clockOutDisableN = 1'b0;
      rise_gap(2, n);
      check("instgap", 8'(n), 8'h30);
      for (int i = 0; i < 30; i++)
      begin
         @(negedge mclk);
         check("oen", instrClockOutOeN, 8'h00);
         check("pin", instrClockOutPin, instrClock);
      end
      // Pin released to general use
      clockOutDisableN = 1'b1;
      for (int i = 0; i < 30; i++)
      begin
         @(negedge mclk);
         check("oenoff", instrClockOutOeN, 8'h01);
         check("pinoff", instrClockOutPin, 8'h00);
      end
      give_verdict();
   end
endmodule : testbench
